// ==== hdl/status_fault_indicator.sv ====
// Chosen here: the address map and register access over AHB-Lite.
module status_fault_indicator #(
	parameter int TICK_CYCLES = status_fault_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Operator controls from pins.
	input  wire logic        throttleRest,
	input  wire logic        freewheel,
	input  wire logic        inhibit,
	// Fault causes and battery level from on-chip monitors.
	input  wire logic [9:0]  faultCause,
	input  wire logic [7:0]  battLevel,
	// Indicator and drive outputs.
	output logic             lampOn,
	output logic      [9:0]  gaugeBars,
	output logic             driveEnable,
	output logic             brakeApply,
	output logic      [7:0]  speedLimit,
	output logic             checkStrobe
);
	typedef struct packed {
		status_fault_pkg::state_type st;
		logic [status_fault_pkg::TICK_W-1:0] halfCnt;
		logic                                pushedSeen;
		logic [5:0]                          slowCnt;
		logic [5:0]                          fastCnt;
		logic                                slowPh;
		logic                                fastPh;
		logic [3:0]                          ripple;
		logic                                rippleUp;
		logic [5:0]                          brakeCnt;
		logic [7:0]                          chargeEst;
		logic [status_fault_pkg::TICK_W-1:0] refineCnt;
		logic                                estOk;
		logic [3:0]                          code;
		logic                                segMode;
		logic [7:0]                          maxSpeed;
		logic                                wrPend;
		logic [7:0]                          wrAddr;
		logic [31:0]                         hrdata;
		logic                                hreadyout;
		logic                                lampOn;
		logic [9:0]                          gaugeBars;
		logic                                driveEnable;
		logic                                brakeApply;
		logic [7:0]                          speedLimit;
		logic                                checkStrobe;
	} core_type;

	core_type   core_q, core_d;
	logic [2:0] pins;
	logic       restS, fwS, inhS, tick;
	logic [9:0] cause;
	logic       lowCharge, driving, brakeDue;

	pin_sync #(
		.W (3)
	) u_pin_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pinIn   ({throttleRest, freewheel, inhibit}),
		.pinOut  (pins)
	);

	tick_divider #(
		.PERIOD (TICK_CYCLES)
	) u_tick_divider (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (tick)
	);

	assign restS = pins[2];
	assign fwS   = pins[1];
	assign inhS  = pins[0];

	always_comb begin
		core_d             = core_q;
		core_d.checkStrobe = tick;
		cause              = faultCause;
		cause[3]           = faultCause[3] | fwS;
		cause[5]           = faultCause[5] | inhS;
		lowCharge          = core_q.chargeEst < status_fault_pkg::LOW_LEVEL;
		driving            = core_q.driveEnable && !restS;
		brakeDue           = core_q.brakeCnt >= 6'(status_fault_pkg::BRAKE_TICKS);

		// Self-check cycle: fault causes, flash phases and ripple advance per tick.
		if (tick) begin
			core_d.code = status_fault_pkg::faultCode(cause);
			if (core_q.slowCnt == 6'(status_fault_pkg::SLOW_TICKS - 1)) begin
				core_d.slowCnt = '0;
				core_d.slowPh  = !core_q.slowPh;
			end else begin
				core_d.slowCnt = core_q.slowCnt + 6'h01;
			end
			if (core_q.fastCnt == 6'(status_fault_pkg::FAST_TICKS - 1)) begin
				core_d.fastCnt = '0;
				core_d.fastPh  = !core_q.fastPh;
			end else begin
				core_d.fastCnt = core_q.fastCnt + 6'h01;
			end
			if (core_q.rippleUp) begin
				core_d.ripple   = core_q.ripple + 4'h1;
				core_d.rippleUp = core_q.ripple != 4'(status_fault_pkg::BARS - 2);
			end else begin
				core_d.ripple   = core_q.ripple - 4'h1;
				core_d.rippleUp = core_q.ripple == 4'h1;
			end
			if (restS) begin
				if (!brakeDue) begin
					core_d.brakeCnt = core_q.brakeCnt + 6'h01;
				end
			end else begin
				core_d.brakeCnt = '0;
			end
			// Estimate moves an eighth of the way toward the measured level each tick while driving.
			if (driving) begin
				core_d.chargeEst = 8'(int'(core_q.chargeEst)
					+ ((int'(battLevel) - int'(core_q.chargeEst))
					>>> status_fault_pkg::REFINE_SHIFT));
				if (core_q.refineCnt != 13'(status_fault_pkg::REFINE_TICKS))
				begin
					core_d.refineCnt = core_q.refineCnt + 13'h0001;
				end else begin
					core_d.estOk = 1'b1;
				end
			end
		end

		unique case (core_q.st)
			status_fault_pkg::ST_CHECK: begin
				// Sampled on the tick only, so the synchroniser's reset level cannot fake a push.
				if (tick && !restS) begin
					core_d.pushedSeen = 1'b1;
				end
				if (tick) begin
					core_d.halfCnt = core_q.halfCnt + 13'h0001;
					if (core_q.halfCnt == 13'(status_fault_pkg::HALF_TICKS - 1)) begin
						core_d.chargeEst = battLevel;
						if (core_q.pushedSeen || !restS) begin
							core_d.st = status_fault_pkg::ST_INTERLOCK;
						end else begin
							core_d.st = status_fault_pkg::ST_RUN;
						end
					end
				end
			end
			status_fault_pkg::ST_INTERLOCK: begin
				if (restS) begin
					core_d.st = status_fault_pkg::ST_RUN;
				end
			end
			status_fault_pkg::ST_RUN: begin
				if (core_q.code != status_fault_pkg::CODE_NONE) begin
					core_d.st = status_fault_pkg::ST_FAULT;
				end
			end
			status_fault_pkg::ST_FAULT: begin
				if (core_q.code == status_fault_pkg::CODE_NONE && restS) begin
					core_d.st = status_fault_pkg::ST_RUN;
				end
			end
		endcase

		// Drive, brake and speed limit.
		core_d.driveEnable = core_q.st == status_fault_pkg::ST_RUN
			&& core_q.code == status_fault_pkg::CODE_NONE && !fwS;
		if (fwS) begin
			core_d.brakeApply = 1'b0;
			core_d.speedLimit = status_fault_pkg::pctOf(core_q.maxSpeed,
				status_fault_pkg::FREEWHEEL_PCT);
		end else begin
			core_d.brakeApply = !core_q.driveEnable || (restS && brakeDue);
			core_d.speedLimit = core_q.maxSpeed;
		end

		// Indicator: self check first, then interlock, then fault, then charge level.
		unique case (core_q.st)
			status_fault_pkg::ST_CHECK: begin
				core_d.lampOn    = 1'b1;
				core_d.gaugeBars = core_q.fastPh ? '1 : '0;
			end
			status_fault_pkg::ST_INTERLOCK: begin
				core_d.lampOn    = core_q.fastPh;
				core_d.gaugeBars = 10'(11'h001 << core_q.ripple);
			end
			status_fault_pkg::ST_FAULT: begin
				core_d.lampOn    = core_q.fastPh;
				core_d.gaugeBars = core_q.fastPh
					? status_fault_pkg::barMask(core_q.code) : '0;
			end
			status_fault_pkg::ST_RUN: begin
				core_d.lampOn = lowCharge ? core_q.slowPh : 1'b1;
				if (core_q.chargeEst >= status_fault_pkg::GREEN_LEVEL) begin
					core_d.gaugeBars = status_fault_pkg::RED_MASK | status_fault_pkg::YEL_MASK
						| status_fault_pkg::GRN_MASK;
				end else if (!lowCharge) begin
					core_d.gaugeBars = status_fault_pkg::RED_MASK
						| status_fault_pkg::YEL_MASK;
				end else if (core_q.chargeEst < status_fault_pkg::CRIT_LEVEL) begin
					core_d.gaugeBars = core_q.slowPh ? status_fault_pkg::RED_MASK : '0;
				end else begin
					core_d.gaugeBars = status_fault_pkg::RED_MASK;
				end
			end
		endcase

		// AHB-Lite slave, zero wait states, always OKAY.
		core_d.hreadyout = 1'b1;
		if (core_q.wrPend) begin
			core_d.wrPend = 1'b0;
			unique case (core_q.wrAddr)
				status_fault_pkg::CTRL_ADDR: begin
					core_d.segMode = hwdata[status_fault_pkg::CTRL_SEG];
				end
				status_fault_pkg::DRIVE_ADDR: begin
					core_d.maxSpeed = hwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		if (hsel && hready && htrans[1]) begin
			core_d.wrPend = hwrite;
			core_d.wrAddr = haddr[7:0];
			core_d.hrdata = '0;
			if (!hwrite) begin
				unique case (haddr[7:0])
					status_fault_pkg::CTRL_ADDR: begin
						core_d.hrdata[status_fault_pkg::CTRL_SEG] = core_q.segMode;
					end
					status_fault_pkg::DRIVE_ADDR: begin
						core_d.hrdata[7:0] = core_q.maxSpeed;
					end
					status_fault_pkg::STATUS_ADDR: begin
						core_d.hrdata[status_fault_pkg::ST_CODE_LO +: 4]  = core_q.code;
						core_d.hrdata[status_fault_pkg::ST_STATE_LO +: 2] = core_q.st;
						core_d.hrdata[status_fault_pkg::ST_EST_OK]        = core_q.estOk;
						core_d.hrdata[status_fault_pkg::ST_BRAKE]         = core_q.brakeApply;
						core_d.hrdata[status_fault_pkg::ST_EST_LO +: 8]   = core_q.chargeEst;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_q            <= '0;
			core_q.st         <= status_fault_pkg::ST_CHECK;
			core_q.rippleUp   <= 1'b1;
			core_q.maxSpeed   <= status_fault_pkg::MAX_SPEED_RST;
			core_q.brakeApply <= 1'b1;
		end else begin
			core_q <= core_d;
		end
	end

	assign hrdata      = core_q.hrdata;
	assign hreadyout   = core_q.hreadyout;
	assign hresp       = 1'b0;
	assign lampOn      = core_q.lampOn;
	assign gaugeBars   = core_q.gaugeBars;
	assign driveEnable = core_q.driveEnable;
	assign brakeApply  = core_q.brakeApply;
	assign speedLimit  = core_q.speedLimit;
	assign checkStrobe = core_q.checkStrobe;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence endOfCheck;
		core_q.st == status_fault_pkg::ST_CHECK && tick
			&& core_q.halfCnt == 13'(status_fault_pkg::HALF_TICKS - 1);
	endsequence
	sequence restHeld;
		(tick && restS && !fwS && core_q.brakeCnt == 6'(status_fault_pkg::BRAKE_TICKS - 1))
			##1 (restS && !fwS);
	endsequence

	AST_CHECK_STROBE: assert property (tick |=> checkStrobe ##1 !checkStrobe)
		else $error("self-check strobe not one cycle after tick");
	AST_INTERLOCK: assert property (core_q.st == status_fault_pkg::ST_INTERLOCK |=> !driveEnable)
		else $error("drive allowed during power-on interlock");
	AST_HALF_SECOND: assert property (endOfCheck |=> core_q.st != status_fault_pkg::ST_CHECK)
		else $error("power-on check did not end after half a second");
	AST_BRAKE_REST: assert property (restHeld |=> brakeApply)
		else $error("brake not applied after throttle rest delay");
	AST_STEADY: assert property ((core_q.st == status_fault_pkg::ST_RUN
		&& core_q.chargeEst >= status_fault_pkg::LOW_LEVEL) |=> lampOn)
		else $error("lamp not steady with adequate charge");
	AST_LOW_FLASH: assert property (
		(core_q.st == status_fault_pkg::ST_RUN && lowCharge)
		|=> lampOn == $past(core_q.slowPh))
		else $error("lamp not slow flashing at low charge");
	AST_FAULT_STOP: assert property (core_q.st == status_fault_pkg::ST_FAULT |=> !driveEnable)
		else $error("drive allowed in fault state");
	AST_FAULT_BARS: assert property (
		(core_q.st == status_fault_pkg::ST_FAULT && core_q.fastPh)
		|=> gaugeBars == status_fault_pkg::barMask($past(core_q.code)))
		else $error("flashing bar count differs from fault code");
	AST_FREEWHEEL: assert property (fwS |=> !driveEnable && speedLimit
		== status_fault_pkg::pctOf($past(core_q.maxSpeed), status_fault_pkg::FREEWHEEL_PCT))
		else $error("freewheel limit or drive block wrong");
	AST_FAULT_FIRST: assert property ((core_q.st == status_fault_pkg::ST_RUN
		&& core_q.code != status_fault_pkg::CODE_NONE)
		|=> core_q.st == status_fault_pkg::ST_FAULT)
		else $error("fault did not take priority");
endmodule : status_fault_indicator

// ==== hdl/status_fault_pkg.sv ====
package status_fault_pkg;
	localparam int CLK_HZ         = 125_000_000;
	localparam int SELF_CHECK_HZ  = 100;
	localparam int TICK_CYCLES    = CLK_HZ / SELF_CHECK_HZ;
	localparam int HALF_SEC_MS    = 500;
	localparam int SLOW_HALF_MS   = 500;
	localparam int FAST_HALF_MS   = 100;
	localparam int BRAKE_DELAY_MS = 200;
	localparam int REFINE_MS      = 60_000;
	localparam int HALF_TICKS     = HALF_SEC_MS * SELF_CHECK_HZ / 1000;
	localparam int SLOW_TICKS     = SLOW_HALF_MS * SELF_CHECK_HZ / 1000;
	localparam int FAST_TICKS     = FAST_HALF_MS * SELF_CHECK_HZ / 1000;
	localparam int BRAKE_TICKS    = BRAKE_DELAY_MS * SELF_CHECK_HZ / 1000;
	localparam int REFINE_TICKS   = REFINE_MS * SELF_CHECK_HZ / 1000;
	localparam int TICK_W         = 13;
	localparam int BARS           = 10;
	localparam int REFINE_SHIFT   = 3;

	typedef enum logic [1:0] {
		ST_CHECK     = 2'b00,
		ST_INTERLOCK = 2'b01,
		ST_RUN       = 2'b10,
		ST_FAULT     = 2'b11
	} state_type;

	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] DRIVE_ADDR  = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	localparam int         CTRL_SEG    = 0;
	localparam int         ST_CODE_LO  = 0;
	localparam int         ST_STATE_LO = 4;
	localparam int         ST_EST_OK   = 6;
	localparam int         ST_BRAKE    = 7;
	localparam int         ST_EST_LO   = 8;
	localparam logic [7:0] MAX_SPEED_RST = 8'hFF;

	localparam int         FREEWHEEL_PCT = 75;
	localparam int         LOW_PCT       = 20;
	localparam int         GREEN_PCT     = 50;
	localparam int         CRIT_PCT      = 10;
	localparam logic [7:0] FULL_LEVEL    = 8'hFF;
	localparam logic [7:0] LOW_LEVEL     = 8'(int'(FULL_LEVEL) * LOW_PCT / 100);
	localparam logic [7:0] GREEN_LEVEL   = 8'(int'(FULL_LEVEL) * GREEN_PCT / 100);
	localparam logic [7:0] CRIT_LEVEL    = 8'(int'(FULL_LEVEL) * CRIT_PCT / 100);
	localparam logic [9:0] RED_MASK      = 10'h003;
	localparam logic [9:0] YEL_MASK      = 10'h01C;
	localparam logic [9:0] GRN_MASK      = 10'h3E0;
	localparam logic [3:0] CODE_NONE     = 4'h0;
	localparam logic [3:0] CODE_FREEWHEEL = 4'h4;
	localparam logic [3:0] CODE_INHIBIT  = 4'h6;
	localparam int         UNUSED_BIT    = 4;

	// Lowest numbered active cause wins; bit i of the cause vector is code i+1, except UNUSED_BIT (bit 4), which is ignored.
	function automatic logic [3:0] faultCode(input logic [9:0] cause);
		logic [3:0] c;
		c = CODE_NONE;
		for (int i = BARS - 1; i >= 0; i--) begin
			if (cause[i] && i != UNUSED_BIT) begin
				c = 4'(i + 1);
			end
		end
		return c;
	endfunction : faultCode

	function automatic logic [9:0] barMask(input logic [3:0] n);
		return 10'((11'h001 << n) - 11'h001);
	endfunction : barMask

	function automatic logic [7:0] pctOf(input logic [7:0] v, input int pct);
		return 8'(int'(v) * pct / 100);
	endfunction : pctOf
endpackage : status_fault_pkg

// ==== hdl/pin_sync.sv ====
module pin_sync #(
	parameter int W = 3
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// Raw pins and their settled copies.
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} sync_type;

	sync_type sync_q, sync_d;

	// A change is taken only once the second and third stages agree.
	always_comb begin
		sync_d    = sync_q;
		sync_d.s1 = pinIn;
		sync_d.s2 = sync_q.s1;
		sync_d.s3 = sync_q.s2;
		for (int i = 0; i < W; i++) begin
			if (sync_q.s2[i] == sync_q.s3[i]) begin
				sync_d.out[i] = sync_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= '0;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign pinOut = sync_q.out;
endmodule : pin_sync

// ==== hdl/tick_divider.sv ====
module tick_divider #(
	parameter int PERIOD = 1000
) (
	// Clock and reset.
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// One-cycle enable every PERIOD cycles.
	output logic      tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} div_type;

	div_type div_q, div_d;

	always_comb begin
		div_d      = div_q;
		div_d.tick = 1'b0;
		if (div_q.cnt == 32'(PERIOD - 1)) begin
			div_d.cnt  = '0;
			div_d.tick = 1'b1;
		end else begin
			div_d.cnt = div_q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign tick = div_q.tick;
endmodule : tick_divider

// ==== tb/operator_panel.sv ====
module operator_panel (
	// Clock.
	input  wire logic clk_sys,
	// Control positions chosen by the bench.
	input  wire logic wantRest,
	input  wire logic wantFree,
	input  wire logic wantInhibit,
	// Control pins towards the block.
	output logic      throttleRest,
	output logic      freewheel,
	output logic      inhibit,
	// The lamp as the operator sees it.
	input  wire logic lampOn,
	output int        lampHalf,
	output int        lampEdges
);
	timeunit 1ns;
	timeprecision 1ps;

	int   run;
	logic lampSeen;

	initial begin
		throttleRest = 1'b1;
		freewheel    = 1'b0;
		inhibit      = 1'b0;
		lampHalf     = 0;
		lampEdges    = 0;
		run          = 0;
		lampSeen     = 1'b0;
	end

	// Switches move only on a clock edge and then hold their level.
	always @(posedge clk_sys) begin
		throttleRest <= wantRest;
		freewheel    <= wantFree;
		inhibit      <= wantInhibit;
		lampSeen     <= lampOn;
		// Each lamp change records the length of the half period just ended.
		if (lampOn !== lampSeen) begin
			lampHalf  <= run;
			lampEdges <= lampEdges + 1;
			run       <= 1;
		end else begin
			run <= run + 1;
		end
	end
endmodule : operator_panel

// ==== tb/status_fault_indicator_tb_top.sv ====
module status_fault_indicator_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TC   = 20;
	localparam int FAST = status_fault_pkg::FAST_TICKS * TC;
	localparam int SLOW = status_fault_pkg::SLOW_TICKS * TC;

	logic        clk_sys     = 1'b0;
	logic        rst_n       = 1'b0;
	logic        hsel        = 1'b0;
	logic [31:0] haddr       = 32'h0;
	logic [1:0]  htrans      = 2'h0;
	logic        hwrite      = 1'b0;
	logic [31:0] hwdata      = 32'h0;
	logic [9:0]  faultCause  = 10'h000;
	logic [7:0]  battLevel   = 8'h00;
	logic        wantRest    = 1'b1;
	logic        wantFree    = 1'b0;
	logic        wantInhibit = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        throttleRest;
	logic        freewheel;
	logic        inhibit;
	logic        lampOn;
	logic [9:0]  gaugeBars;
	logic        driveEnable;
	logic        brakeApply;
	logic [7:0]  speedLimit;
	logic        checkStrobe;
	logic [31:0] rd;
	logic [7:0]  maxSpeed;
	logic [9:0]  cause;
	logic [9:0]  barsSeen;
	int          lampHalf;
	int          lampEdges;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          seed       = 25;
	int          n;
	int          e0;

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	status_fault_indicator #(.TICK_CYCLES(TC)) i_status_fault_indicator (
		.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.throttleRest(throttleRest), .freewheel(freewheel), .inhibit(inhibit),
		.faultCause(faultCause), .battLevel(battLevel), .lampOn(lampOn),
		.gaugeBars(gaugeBars), .driveEnable(driveEnable), .brakeApply(brakeApply),
		.speedLimit(speedLimit), .checkStrobe(checkStrobe)
	);

	operator_panel i_operator_panel (
		.clk_sys(clk_sys), .wantRest(wantRest), .wantFree(wantFree),
		.wantInhibit(wantInhibit), .throttleRest(throttleRest), .freewheel(freewheel),
		.inhibit(inhibit), .lampOn(lampOn), .lampHalf(lampHalf), .lampEdges(lampEdges)
	);

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task final_report;
		$display("comparisons %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task timedOut;
		fail_count++;
		$display("[ERR] %0t wait ran out", $time);
		final_report();
	endtask : timedOut

	task waitRdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		if (hreadyout !== 1'b1) timedOut();
	endtask : waitRdy

	// One single word transfer; read data lands in rd.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		waitRdy();
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
		check(hresp, 1'b0);
	endtask : ahb

	task waitTicks(input int t);
		int k;
		int lim;
		k = 0;
		lim = t * TC + 100;
		while (t > 0 && k < lim) begin
			@(posedge clk_sys);
			k++;
			if (checkStrobe === 1'b1) t--;
		end
		if (t > 0) timedOut();
	endtask : waitTicks

	task lampCheck(input int exp);
		int k;
		int e;
		e = lampEdges;
		k = 0;
		while (lampEdges < e + 3 && k < 4 * SLOW) begin
			@(posedge clk_sys);
			k++;
		end
		if (lampEdges < e + 3) timedOut();
		check(lampHalf, exp);
	endtask : lampCheck

	task steadyCheck;
		int e;
		e = lampEdges;
		repeat (2 * SLOW) @(posedge clk_sys);
		check(lampEdges, e);
		check(lampOn, 1'b1);
	endtask : steadyCheck

	// A fresh power-on, checked while the start-up self check still runs.
	task powerOn(input logic rest, input logic [7:0] batt);
		rst_n       <= 1'b0;
		wantRest    <= rest;
		battLevel   <= batt;
		faultCause  <= 10'h000;
		wantFree    <= 1'b0;
		wantInhibit <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check(brakeApply, 1'b1);
		rst_n <= 1'b1;
		waitTicks(status_fault_pkg::HALF_TICKS - 5);
		ahb(1'b0, 32'(status_fault_pkg::STATUS_ADDR), 32'h0);
		check(rd[5:4], 2'h0);
		check(driveEnable, 1'b0);
		waitTicks(8);
	endtask : powerOn

	initial begin
		powerOn(1'b0, 8'hF0);
		ahb(1'b0, 32'(status_fault_pkg::STATUS_ADDR), 32'h0);
		check(rd[5:4], 2'h1);
		check(driveEnable, 1'b0);
		lampCheck(FAST);
		wantRest <= 1'b1;
		waitTicks(3);
		check(driveEnable, 1'b1);
		ahb(1'b0, 32'(status_fault_pkg::STATUS_ADDR), 32'h0);
		check(rd[15:8], 8'hF0);
		check(rd[5:4], 2'h2);
		check(gaugeBars, 10'h3FF);
		steadyCheck();
		waitTicks(1);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (checkStrobe !== 1'b1 && n < 100);
		check(n, TC);
		ahb(1'b0, 32'(status_fault_pkg::DRIVE_ADDR), 32'h0);
		check(rd, 32'h0000_00FF);
		ahb(1'b0, 32'h0000_000C, 32'h0);
		check(rd, 32'h0);
		maxSpeed = 8'($random(seed));
		// The bench keeps its own record of the setting it changed.
		ahb(1'b1, 32'(status_fault_pkg::DRIVE_ADDR), {24'h0, maxSpeed});
		ahb(1'b0, 32'(status_fault_pkg::DRIVE_ADDR), 32'h0);
		check(rd[7:0], maxSpeed);
		waitTicks(2);
		check(speedLimit, maxSpeed);
		wantFree <= 1'b1;
		waitTicks(3);
		check(speedLimit, 8'(int'(maxSpeed) * 75 / 100));
		check(driveEnable, 1'b0);
		ahb(1'b0, 32'(status_fault_pkg::STATUS_ADDR), 32'h0);
		check(rd[3:0], 4'h4);
		wantFree <= 1'b0;
		waitTicks(3);
		check(speedLimit, maxSpeed);
		check(driveEnable, 1'b1);
		wantRest <= 1'b0;
		waitTicks(3);
		check(brakeApply, 1'b0);
		wantRest <= 1'b1;
		waitTicks(status_fault_pkg::BRAKE_TICKS + 3);
		check(brakeApply, 1'b1);
		powerOn(1'b1, 8'h60);
		check(gaugeBars, 10'h01F);
		steadyCheck();
		powerOn(1'b1, 8'h20 | (8'($random(seed)) & 8'h0F));
		lampCheck(SLOW);
		check(driveEnable, 1'b1);
		check(gaugeBars & ~status_fault_pkg::RED_MASK, 10'h000);
		for (int i = 0; i < 10; i++) begin
			// Random causes above the forced one must not win over it.
			cause = (10'($random(seed)) & (10'h3FF << i)) | (10'h001 << i);
			if (i == 4) cause = 10'h010;
			if (i == 5) begin
				cause = 10'h000;
				wantInhibit <= 1'b1;
			end
			faultCause <= cause;
			waitTicks(3);
			ahb(1'b0, 32'(status_fault_pkg::STATUS_ADDR), 32'h0);
			check(rd[3:0], (i == 4) ? 4'h0 : 4'(i + 1));
			if (i != 4) begin
				check(driveEnable, 1'b0);
				lampCheck(FAST);
				barsSeen = 10'h000;
				repeat (2 * FAST) begin
					@(posedge clk_sys);
					barsSeen = barsSeen | gaugeBars;
				end
				check(barsSeen, 10'((11'h001 << (i + 1)) - 11'h001));
			end
			faultCause  <= 10'h000;
			wantInhibit <= 1'b0;
			waitTicks(3);
			check(driveEnable, 1'b1);
		end
		final_report();
	end
endmodule : status_fault_indicator_tb_top
